// >>> sdis_init_seq.sv
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
// Notes on behaviour
// - Keep driving strobe for leveling delay, release
// - Drop termination input after strobe, hold low
// - Leveling off by mode load, then delays
// - Hold reset pin low at least 200us
// - Clock gate low 10ns before reset release
// - Wait 500us less one clock, gate low
// - Clock valid, termination low, then only idles
// - Clock gate stays high through initialization
// - First mode load targets register two
// - Then registers three, one, zero with reset
// - DLL needs 512 clocks to lock
// - Long calibration; wait calibration and lock
// - Voltage change: idles, then relock and calibrate
// - Every mode load carries all fields
// - Mode load only with banks idle, precharged
// - Mode loads spaced by mode-to-mode delay
// - Clock gate high until powerdown delay passes
// - Only idles or mode loads before update delay
// - Termination low during mode update delay
module sdis_init_seq
  import sdis_pkg::*;
#(
  parameter int RST_LOW_CYC_P = RST_LOW_CYC,
  parameter int CKE_WAIT_CYC_P = CKE_WAIT_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic ddr_ck,
  output logic ddr_reset_n,
  output logic ddr_cke,
  output logic ddr_odt,
  output logic ddr_cs_n,
  output logic ddr_ras_n,
  output logic ddr_cas_n,
  output logic ddr_we_n,
  output logic [2:0] ddr_ba,
  output logic [15:0] ddr_addr,
  output logic ddr_dqs_o,
  output logic ddr_dqs_oe
);
  localparam logic [15:0] RST_CK = 16'((RST_LOW_CYC_P + CK_DIV - 1) / CK_DIV);
  localparam logic [15:0] CKEW_CK = 16'((CKE_WAIT_CYC_P + CK_DIV - 1) / CK_DIV - 1);

  sdis_state_t state_r, state_nxt;
  sdis_kind_t kind_r;
  logic [3:0] div_r;
  logic ck_r, fall_tick;
  logic [15:0] wait_r, wait_val, dll_r;
  logic wait_ld, go_r, done_r, vok_r, odt_en_r;
  logic [1:0] idx_r, idx_nxt, sel_r, tgt;
  logic [15:0] mr_r [0:3];
  logic [15:0] dly_r [0:NUM_DLY-1];
  logic [15:0] mr_val;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] rdata;

  // ==========================================================
  // Link clock divider; commands change on the falling edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r <= 4'h0;
      ck_r <= 1'b0;
    end else begin
      div_r <= (div_r == 4'(CK_HALF - 1)) ? 4'h0 : div_r + 4'h1;
      if (div_r == 4'(CK_HALF - 1)) ck_r <= ~ck_r;
    end
  end
  assign fall_tick = (div_r == 4'(CK_HALF - 1)) && ck_r;

  // ==========================================================
  // AHB-Lite slave: zero wait state, always OKAY
  always_comb begin
    rdata = 32'h0000_0000;
    case (haddr[7:0])
      A_CTRL: rdata = {22'h0, odt_en_r, vok_r, 2'h0, sel_r, 1'b0, kind_r};
      A_STAT: rdata = {23'h0, (dll_r != 16'h0), done_r, (state_r != S_IDLE), 2'h0, state_r};
      default: begin
        if (haddr[7:4] == A_MR_BASE[7:4])
          rdata = {16'h0, mr_r[haddr[3:2]]};
        else if (haddr[7:5] == A_DLY_BASE[7:5] && haddr[4:2] != 3'h7)
          rdata = {16'h0, dly_r[haddr[4:2]]};
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_r <= hsel && htrans[1] && hready && hwrite && (hsize == 3'h2);
      if (hsel && htrans[1] && hready) begin
        wr_addr_r <= haddr[7:0];
        if (!hwrite) hrdata <= rdata;
      end
    end
  end

  // Orders are taken only while idle; a stale order would break sequencing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      go_r <= 1'b0;
      kind_r <= K_NONE;
      sel_r <= 2'h0;
      vok_r <= 1'b0;
      odt_en_r <= 1'b0;
    end else begin
      if (wr_pend_r && wr_addr_r == A_CTRL) begin
        vok_r <= hwdata[CTRL_VOK_BIT];
        odt_en_r <= hwdata[CTRL_ODT_BIT];
        if (!go_r && state_r == S_IDLE && (done_r || hwdata[2:0] == K_INIT)
            && hwdata[2:0] inside {K_INIT, K_WLX, K_VCHG, K_MODE}) begin
          go_r <= 1'b1;
          kind_r <= sdis_kind_t'(hwdata[CTRL_CMD_LSB +: 3]);
          sel_r <= hwdata[CTRL_SEL_LSB +: 2];
        end
      end
      if (fall_tick && state_r == S_IDLE && state_nxt != S_IDLE) go_r <= 1'b0;
    end
  end

  // Full field sets are stored so each mode load carries all of them
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_mr
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) mr_r[gi] <= 16'h0000;
        else if (wr_pend_r && wr_addr_r == A_MR_BASE + 8'(4 * gi)) mr_r[gi] <= hwdata[15:0];
      end
    end
    for (gi = 0; gi < NUM_DLY; gi++) begin : g_dly
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) dly_r[gi] <= DLY_RST[gi];
        else if (wr_pend_r && wr_addr_r == A_DLY_BASE + 8'(4 * gi)) dly_r[gi] <= hwdata[15:0];
      end
    end
  endgenerate

  // ==========================================================
  // Mode load target and value
  always_comb begin
    idx_nxt = (state_r == S_MRS) ? idx_r + 2'h1 : idx_r;
    case (kind_r)
      K_INIT: tgt = (idx_nxt == 2'h0) ? 2'h2 : (idx_nxt == 2'h1) ? 2'h3 :
                    (idx_nxt == 2'h2) ? 2'h1 : 2'h0;
      K_WLX: tgt = 2'h1;
      K_VCHG: tgt = 2'h0;
      default: tgt = sel_r;
    endcase
    mr_val = mr_r[tgt];
    if (tgt == 2'h0 && (kind_r == K_INIT || kind_r == K_VCHG))
      mr_val[MR0_DLL_RST_BIT] = 1'b1;
    if (kind_r == K_WLX) mr_val[MR1_WL_BIT] = 1'b0;
  end

  // ==========================================================
  // Sequencer, stepping once per link clock period
  always_comb begin
    state_nxt = state_r;
    wait_ld = 1'b0;
    wait_val = 16'h0000;
    case (state_r)
      S_IDLE: begin
        if (go_r) begin
          wait_ld = 1'b1;
          case (kind_r)
            K_INIT: begin
              state_nxt = S_RST;
              wait_val = RST_CK;
            end
            K_WLX: begin
              state_nxt = S_WLD;
              wait_val = dly_r[D_WLO];
            end
            K_VCHG: state_nxt = S_VC;
            default: state_nxt = S_MRS;
          endcase
        end
      end
      S_RST: if (wait_r == 16'h0) begin
        state_nxt = S_CKEW;
        wait_ld = 1'b1;
        wait_val = CKEW_CK;
      end
      S_CKEW: if (wait_r == 16'h0) begin
        state_nxt = S_XPR;
        wait_ld = 1'b1;
        wait_val = dly_r[D_XPR];
      end
      S_XPR, S_WLO: if (wait_r == 16'h0) state_nxt = S_MRS;
      S_MRS: begin
        wait_ld = 1'b1;
        if (kind_r != K_INIT || idx_r == 2'h3) begin
          state_nxt = S_MOD;
          wait_val = dly_r[D_MOD];
        end else begin
          state_nxt = S_GAP;
          wait_val = dly_r[D_MRD];
        end
      end
      S_GAP: if (wait_r == 16'h0) state_nxt = S_MRS;
      S_MOD: if (wait_r == 16'h0)
        state_nxt = (kind_r == K_INIT || kind_r == K_VCHG) ? S_ZQ : S_IDLE;
      S_ZQ: begin
        state_nxt = S_ZQW;
        wait_ld = 1'b1;
        wait_val = dly_r[D_ZQI];
      end
      S_ZQW: if (wait_r == 16'h0 && dll_r == 16'h0) state_nxt = S_IDLE;
      S_WLD: if (wait_r == 16'h0) begin
        state_nxt = S_WLO;
        wait_ld = 1'b1;
        wait_val = dly_r[D_TOFF];
      end
      S_VC: if (vok_r) state_nxt = S_MRS;
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= S_IDLE;
      wait_r <= 16'h0000;
      idx_r <= 2'h0;
    end else if (fall_tick) begin
      state_r <= state_nxt;
      if (wait_ld) wait_r <= wait_val;
      else if (wait_r != 16'h0) wait_r <= wait_r - 16'h1;
      idx_r <= (state_nxt == S_IDLE) ? 2'h0 : idx_nxt;
    end
  end

  // DLL lock runs from the mode load that resets it, overlapping calibration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) dll_r <= 16'h0000;
    else if (fall_tick) begin
      if (state_nxt == S_MRS && tgt == 2'h0 && mr_val[MR0_DLL_RST_BIT]) dll_r <= dly_r[D_DLLK];
      else if (dll_r != 16'h0) dll_r <= dll_r - 16'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) done_r <= 1'b0;
    else if (fall_tick && state_r == S_IDLE && state_nxt == S_RST) done_r <= 1'b0;
    else if (fall_tick && state_r == S_ZQW && state_nxt == S_IDLE && kind_r == K_INIT)
      done_r <= 1'b1;
  end

  // ==========================================================
  // Pins, all registered; reset pin stays low until the reset hold of init ends
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ddr_ck <= 1'b0;
      ddr_reset_n <= 1'b0;
      ddr_cke <= 1'b0;
      ddr_odt <= 1'b0;
      {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= PIN_NOP;
      ddr_ba <= 3'h0;
      ddr_addr <= 16'h0000;
      ddr_dqs_o <= 1'b0;
      ddr_dqs_oe <= 1'b0;
    end else begin
      ddr_ck <= (div_r == 4'(CK_HALF - 1)) ? ~ck_r : ck_r;
      if (fall_tick) begin
        if (state_nxt == S_RST) ddr_reset_n <= 1'b0;
        else if (state_nxt == S_CKEW) ddr_reset_n <= 1'b1;
        // Gate is low through the whole reset hold, far beyond the setup
        if (state_nxt == S_RST) ddr_cke <= 1'b0;
        else if (state_nxt == S_XPR) ddr_cke <= 1'b1;
        // Termination only while idle after init or while leveling
        ddr_odt <= odt_en_r && done_r && (state_nxt == S_IDLE || state_nxt == S_WLD);
        ddr_ba <= 3'h0;
        ddr_addr <= 16'h0000;
        case (state_nxt)
          S_MRS: begin
            {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= PIN_MRS;
            ddr_ba <= {1'b0, tgt};
            ddr_addr <= mr_val;
          end
          S_ZQ: begin
            {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= PIN_ZQ;
            ddr_addr[ZQ_LONG_BIT] <= 1'b1;
          end
          default: {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= PIN_NOP;
        endcase
        ddr_dqs_o <= 1'b0;
        ddr_dqs_oe <= (state_nxt == S_WLD);
      end
    end
  end

  // ==========================================================
  // Checks
  logic [15:0] rlow_cnt, since_mrs;
  logic mrs_on;
  assign mrs_on = {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} == PIN_MRS;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rlow_cnt <= 16'h0000;
      since_mrs <= 16'hFFFF;
    end else begin
      rlow_cnt <= ddr_reset_n ? 16'h0000 : (rlow_cnt == 16'hFFFF ? rlow_cnt : rlow_cnt + 16'h1);
      if (fall_tick) since_mrs <= (state_nxt == S_MRS) ? 16'h0000 :
        (since_mrs == 16'hFFFF ? since_mrs : since_mrs + 16'h1);
    end
  end

  sequence strobe_released_s;
    $fell(ddr_dqs_oe) && !ddr_odt;
  endsequence
  sequence mode_load_s;
    mrs_on && ddr_ba == 3'h1 && !ddr_addr[MR1_WL_BIT];
  endsequence

  rst_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(ddr_reset_n) |-> $past(rlow_cnt) >= 16'(RST_LOW_CYC_P - 1))
    else $error("reset pin released too early");
  cke_before_rst_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(ddr_reset_n) |-> !ddr_cke && $past(!ddr_cke, CKE_SETUP_CYC))
    else $error("clock gate not low before reset release");
  cke_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ddr_cke && state_r != S_IDLE && state_r != S_RST |=> ddr_cke)
    else $error("clock gate dropped during sequence");
  first_mr2_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fall_tick && state_r == S_XPR && state_nxt == S_MRS |=> mrs_on && ddr_ba == 3'h2)
    else $error("first mode load not to register two");
  mrs_gap_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fall_tick && state_nxt == S_MRS |-> since_mrs > dly_r[D_MRD])
    else $error("mode loads too close");
  odt_mrs_a: assert property (@(posedge hclk) disable iff (!hresetn)
    mrs_on || state_r == S_MOD |-> !ddr_odt)
    else $error("termination high during mode update");
  xpr_nop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == S_XPR || state_r == S_VC |-> {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} == PIN_NOP)
    else $error("non-idle command before mode loads allowed");
  ready_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(done_r) |-> $past(dll_r) == 16'h0 && $past(wait_r) == 16'h0)
    else $error("ready before lock and calibration");
  wl_exit_a: assert property (@(posedge hclk) disable iff (!hresetn)
    strobe_released_s |-> !ddr_odt [*8] ##[1:1000] mode_load_s)
    else $error("leveling exit order broken");

  // Gate-low time after reset release, and link clock run time since system reset
  logic [15:0] ckl_cnt, run_cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ckl_cnt <= 16'h0000;
      run_cnt <= 16'h0000;
    end else begin
      ckl_cnt <= (!ddr_reset_n || ddr_cke) ? 16'h0000 :
        (ckl_cnt == 16'hFFFF ? ckl_cnt : ckl_cnt + 16'h1);
      run_cnt <= (run_cnt == 16'hFFFF) ? run_cnt : run_cnt + 16'h1;
    end
  end

  cke_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(ddr_cke) |-> $past(ckl_cnt) >= 16'(CKE_WAIT_CYC_P - CK_DIV))
    else $error("clock gate raised too soon after reset release");
  clk_valid_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(ddr_cke) |-> $past(run_cnt) >= 16'(CLK_VALID_MIN_CK * CK_DIV))
    else $error("clock gate raised before link clock ran");
endmodule : sdis_init_seq

// >>> sdis_pkg.sv
package sdis_pkg;
  // ==========================================================
  // Clocking and long waits
  localparam int CLK_PERIOD_NS = 10;
  localparam int CK_HALF = 8;
  localparam int CK_DIV = 2 * CK_HALF;
  localparam int T_RST_LOW_NS = 200000;
  localparam int RST_LOW_CYC = (T_RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_CKE_WAIT_NS = 500000;
  localparam int CKE_WAIT_CYC = (T_CKE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_CKE_SETUP_NS = 10;
  localparam int CKE_SETUP_CYC = (T_CKE_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLK_VALID_MIN_CK = 5;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_MR_BASE = 8'h10;
  localparam logic [7:0] A_DLY_BASE = 8'h20;
  localparam int NUM_DLY = 7;
  localparam int CTRL_CMD_LSB = 0;
  localparam int CTRL_SEL_LSB = 4;
  localparam int CTRL_VOK_BIT = 8;
  localparam int CTRL_ODT_BIT = 9;
  // Delay register indices, in link clock cycles
  localparam int D_MOD = 0;
  localparam int D_MRD = 1;
  localparam int D_XPR = 2;
  localparam int D_DLLK = 3;
  localparam int D_ZQI = 4;
  localparam int D_WLO = 5;
  localparam int D_TOFF = 6;
  localparam logic [15:0] DLY_RST [0:NUM_DLY-1] = '{16'h000C, 16'h0004, 16'h0040,
    16'h0200, 16'h0200, 16'h0008, 16'h0008};
  // ==========================================================
  // Mode register bits and pin commands
  localparam int MR1_WL_BIT = 7;
  localparam int MR0_DLL_RST_BIT = 8;
  localparam int ZQ_LONG_BIT = 10;
  localparam logic [3:0] PIN_NOP = 4'h7;
  localparam logic [3:0] PIN_MRS = 4'h0;
  localparam logic [3:0] PIN_ZQ = 4'h6;
  typedef enum logic [2:0] {
    K_NONE = 3'h0, K_INIT = 3'h1, K_WLX = 3'h2, K_VCHG = 3'h3, K_MODE = 3'h4
  } sdis_kind_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_RST = 4'h1, S_CKEW = 4'h3, S_XPR = 4'h2, S_MRS = 4'h6, S_GAP = 4'h7,
    S_MOD = 4'h5, S_ZQ = 4'h4, S_ZQW = 4'hC, S_WLD = 4'hD, S_WLO = 4'hF, S_VC = 4'hE
  } sdis_state_t;
endpackage : sdis_pkg

// >>> sdis_dev_model.sv
`timescale 1ns/100ps
// ==========================================================
// Device model: samples the pins on each link clock rise
module sdis_dev_model #(
  parameter int MOD_CK = 3,
  parameter int MRD_CK = 2
) (
  input wire logic ck,
  input wire logic reset_n,
  input wire logic cke,
  input wire logic term_en,
  input wire logic [3:0] cmd,
  input wire logic [2:0] ba,
  input wire logic [15:0] addr,
  output logic [3:0][15:0] mr,
  output logic [7:0] mr_log,
  output logic [7:0] load_cnt,
  output logic [7:0] cal_cnt,
  output logic [15:0] dll_cnt,
  output logic [7:0] bad,
  output logic term_on
);
  logic [15:0] since_r;
  logic cke_seen_r;
  wire is_load = (cmd == 4'h0);
  wire is_act = !cmd[3] && (cmd != 4'h7) && !is_load;
  wire [15:0] gap = since_r + 16'h1;
  wire v_load = is_load && (gap < 16'(MRD_CK) || ba[2]);
  wire v_cmd = is_act && (gap < 16'(MOD_CK));
  wire v_term = term_en && (is_load || gap < 16'(MOD_CK));
  // ==========================================================
  // Termination stays off until the gate is seen high
  always_ff @(posedge ck or negedge reset_n) begin
    if (!reset_n) begin
      cke_seen_r <= 1'b0;
    end else if (cke) begin
      cke_seen_r <= 1'b1;
    end
  end
  assign term_on = reset_n && cke_seen_r && term_en;
  // ==========================================================
  // Mode registers; a low reset pin wipes them
  always_ff @(posedge ck or negedge reset_n) begin
    if (!reset_n) begin
      mr <= '0;
      mr_log <= 8'h00;
      load_cnt <= 8'h00;
      cal_cnt <= 8'h00;
      dll_cnt <= 16'h0000;
      bad <= 8'h00;
      since_r <= 16'h7FFF;
    end else begin
      bad <= bad + 8'(v_load) + 8'(v_cmd) + 8'(v_term);
      since_r <= (since_r == 16'h7FFF) ? since_r : gap;
      dll_cnt <= (dll_cnt == 16'hFFFF) ? dll_cnt : dll_cnt + 16'h1;
      if (is_load) begin
        // Reset request never sticks in register zero
        mr[ba[1:0]] <= (ba[1:0] == 2'h0) ? (addr & 16'hFEFF) : addr;
        mr_log <= {mr_log[5:0], ba[1:0]};
        load_cnt <= load_cnt + 8'h1;
        since_r <= 16'h0000;
        if (ba[1:0] == 2'h0 && addr[8]) begin
          dll_cnt <= 16'h0000;
        end
      end
      if (is_act && cmd == 4'h6 && addr[10]) begin
        cal_cnt <= cal_cnt + 8'h1;
      end
    end
  end
endmodule : sdis_dev_model

// >>> tb_sdis_init_seq.sv
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
  $display("FAIL t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_sdis_init_seq;
  import sdis_pkg::*;
  localparam int RSTC = 64;
  localparam int CKEC = 64;
  localparam logic [15:0] MV [0:3] = '{16'h0D14, 16'h0086, 16'h0018, 16'h0004};
  logic hclk, hresetn, hsel, hwrite, hready, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize, ddr_ba;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic ddr_ck, ddr_reset_n, ddr_cke, ddr_odt, ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n;
  logic ddr_dqs_o, ddr_dqs_oe, term_on;
  logic [15:0] ddr_addr, dll_cnt;
  logic [3:0][15:0] mr;
  logic [7:0] mr_log, load_cnt, cal_cnt, bad;
  int miscompares = 0, comparisons = 0, rl = 0, cl = 0, ql = 0, tg = 0, ws = 0;
  logic pr = 1'b0, pc = 1'b0, pq = 1'b0, wl = 1'b0;
  logic [7:0] pm = 8'h00;
  initial hclk = 1'b0;
  always #5 hclk = ~hclk;
  sdis_init_seq #(.RST_LOW_CYC_P(RSTC), .CKE_WAIT_CYC_P(CKEC)) i_sdis_init_seq (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .ddr_ck(ddr_ck), .ddr_reset_n(ddr_reset_n),
    .ddr_cke(ddr_cke), .ddr_odt(ddr_odt), .ddr_cs_n(ddr_cs_n), .ddr_ras_n(ddr_ras_n),
    .ddr_cas_n(ddr_cas_n), .ddr_we_n(ddr_we_n), .ddr_ba(ddr_ba), .ddr_addr(ddr_addr),
    .ddr_dqs_o(ddr_dqs_o), .ddr_dqs_oe(ddr_dqs_oe));
  sdis_dev_model #(.MOD_CK(3), .MRD_CK(2)) i_sdis_dev_model (
    .ck(ddr_ck), .reset_n(ddr_reset_n), .cke(ddr_cke), .term_en(ddr_odt),
    .cmd({ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n}), .ba(ddr_ba), .addr(ddr_addr),
    .mr(mr), .mr_log(mr_log), .load_cnt(load_cnt), .cal_cnt(cal_cnt), .dll_cnt(dll_cnt),
    .bad(bad), .term_on(term_on));
  // ==========================================================
  // Pin timing watched on every system clock
  always @(posedge hclk) begin
    pr <= ddr_reset_n;
    pc <= ddr_cke;
    pq <= ddr_dqs_oe;
    pm <= load_cnt;
    rl <= ddr_reset_n ? 0 : rl + 1;
    cl <= (ddr_reset_n && !ddr_cke) ? cl + 1 : 0;
    ql <= ddr_dqs_oe ? ql + 1 : 0;
    tg <= tg + 1;
    if (ddr_reset_n && !pr) begin
      `CHK(rl >= RSTC, 1'b1)
      `CHK(pc, 1'b0)
    end
    if (ddr_cke && !pc) begin
      `CHK(cl >= CKEC - CK_DIV, 1'b1)
      `CHK(ddr_odt, 1'b0)
    end
    if (pc && ddr_reset_n) `CHK(ddr_cke, 1'b1)
    if (ddr_dqs_oe) `CHK(ddr_dqs_o, 1'b0)
    if (pq && !ddr_dqs_oe) begin
      `CHK(ql >= int'(DLY_RST[D_WLO]) * CK_DIV, 1'b1)
      tg <= 0;
      wl <= 1'b1;
      ws <= ws + 1;
    end
    if (wl && load_cnt != pm) begin
      `CHK(tg >= int'(DLY_RST[D_TOFF]) * CK_DIV, 1'b1)
      `CHK(ddr_odt, 1'b0)
      wl <= 1'b0;
    end
  end
  // ==========================================================
  // Bus cycles
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rv = hrdata;
    `CHK(hresp, 1'b0)
  endtask : ahb
  // Busy may rise only at the next link clock fall, so wait past it
  task automatic wait_idle;
    repeat (3 * CK_DIV) @(posedge hclk);
    do ahb(1'b0, A_STAT, 32'h0); while (rv[6] !== 1'b0);
  endtask : wait_idle
  task automatic give_verdict;
    if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    for (int i = 0; i < NUM_DLY; i++) begin
      ahb(1'b0, A_DLY_BASE + 8'(4 * i), 32'h0);
      `CHK(rv, {16'h0, DLY_RST[i]})
    end
    ahb(1'b0, 8'h40, 32'h0);
    `CHK(rv, 32'h0)
    ahb(1'b1, A_DLY_BASE + 8'(4 * D_MOD), 32'h3);
    ahb(1'b1, A_DLY_BASE + 8'(4 * D_MRD), 32'h2);
    ahb(1'b1, A_DLY_BASE + 8'(4 * D_XPR), 32'h4);
    ahb(1'b1, A_DLY_BASE + 8'(4 * D_ZQI), 32'h10);
    ahb(1'b0, A_DLY_BASE + 8'(4 * D_MRD), 32'h0);
    `CHK(rv, 32'h2)
    for (int i = 0; i < 4; i++) ahb(1'b1, A_MR_BASE + 8'(4 * i), {16'h0, MV[i]});
  endtask : t_regs
  task automatic t_init;
    ahb(1'b1, A_CTRL, 32'h101);
    wait_idle;
    `CHK(rv[7], 1'b1)
    `CHK(dll_cnt >= 16'h0200, 1'b1)
    `CHK(mr_log, 8'hB4)
    `CHK(load_cnt, 8'h04)
    `CHK(mr, {MV[3], MV[2], MV[1], MV[0] & 16'hFEFF})
    `CHK(cal_cnt, 8'h01)
    `CHK(bad, 8'h00)
  endtask : t_init
  task automatic t_wlx;
    ahb(1'b1, A_CTRL, 32'h302);
    wait_idle;
    `CHK(ws, 1)
    `CHK(mr[1], MV[1] & 16'hFF7F)
    `CHK(load_cnt, 8'h05)
    `CHK(bad, 8'h00)
    `CHK(term_on, 1'b1)
  endtask : t_wlx
  // Supplies not yet stable: only idle commands may appear
  task automatic t_vchg;
    ahb(1'b1, A_CTRL, 32'h3);
    repeat (50 * CK_DIV) @(posedge hclk);
    `CHK(load_cnt, 8'h05)
    `CHK(cal_cnt, 8'h01)
    ahb(1'b1, A_CTRL, 32'h100);
    wait_idle;
    `CHK(load_cnt, 8'h06)
    `CHK(mr_log[1:0], 2'h0)
    `CHK(cal_cnt, 8'h02)
    `CHK(dll_cnt >= 16'h0200, 1'b1)
    `CHK(mr[0], MV[0] & 16'hFEFF)
    `CHK(bad, 8'h00)
  endtask : t_vchg
  // Termination is on before the load; a second order lands while the first
  // is pending and must be dropped
  task automatic t_mode;
    ahb(1'b1, A_CTRL, 32'h300);
    repeat (2 * CK_DIV) @(posedge hclk);
    `CHK(term_on, 1'b1)
    ahb(1'b1, A_MR_BASE + 8'h0C, 32'h7);
    ahb(1'b1, A_CTRL, 32'h334);
    ahb(1'b1, A_CTRL, 32'h314);
    wait_idle;
    `CHK(load_cnt, 8'h07)
    `CHK(mr[3], 16'h0007)
    `CHK(mr[1], MV[1] & 16'hFF7F)
    `CHK(bad, 8'h00)
  endtask : t_mode
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs;
    t_init;
    t_wlx;
    t_vchg;
    t_mode;
    give_verdict;
  end
  // Run needs roughly 20k cycles; the margin covers slow sequencing
  initial begin
    #500000;
    miscompares++;
    give_verdict;
  end
endmodule : tb_sdis_init_seq
